//--- dv/tb.sv
// Purpose: Self-checking bench for the scramble number and slot layout.
// Assumes: Zero-wait APB slave; one 40 MHz clock.
// Notes:   Random settings come from an xorshift with a fixed seed.
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, fire = 1'b0, slow = 1'b0, slot_strobe;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'he21a;
   logic pready, pslverr, slot_valid, tfci_dtx, tpc_up, irq, er;
   logic [3:0] slot_index, tfci_len, tpc_len;
   logic [1:0] slot_chan, fbi_len, sch_len;
   logic [10:0] slot_len, data2_len;
   logic [7:0] data1_len, tpc_field;
   logic [4:0] pilot_len;
   logic [14:0] scr_code_num, pat = 15'h0000;
   logic [15:0] n_seen;
   int n_mismatch = 0, check_count = 0, cyc = 0, xs_slot = 0, j, sf, fm, u;
   int dl_len[6] = '{40, 80, 160, 320, 640, 1280};
   int dl_d1[6] = '{6, 12, 28, 56, 120, 248};
   int dl_d2[6] = '{28, 48, 112, 232, 488, 1000};
   int dl_tp[6] = '{2, 4, 4, 8, 8, 8};
   int dl_pl[6] = '{4, 8, 8, 16, 16, 16};
   int uc_pl[6] = '{6, 8, 5, 7, 6, 5};
   int uc_tf[6] = '{2, 0, 2, 0, 0, 2};
   int uc_fb[6] = '{0, 0, 1, 1, 2, 2};
   int uc_tp[6] = '{2, 2, 2, 2, 2, 1};
   int ci[7] = '{6, 8, 6, 8, 511, 511, 511};
   int ck[7] = '{0, 7, 0, 7, 0, 15, 15};
   int cm[7] = '{0, 0, 2, 1, 0, 0, 1};

   wsf_scramble_slot i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .slot_strobe(slot_strobe), .slot_valid(slot_valid),
      .slot_index(slot_index), .slot_chan(slot_chan), .slot_len(slot_len),
      .data1_len(data1_len), .data2_len(data2_len), .tfci_len(tfci_len),
      .tpc_len(tpc_len), .pilot_len(pilot_len), .fbi_len(fbi_len),
      .sch_len(sch_len), .tfci_dtx(tfci_dtx), .tpc_field(tpc_field),
      .tpc_up(tpc_up), .scr_code_num(scr_code_num), .irq(irq));
   wsf_dp_model i_dp (.pclk(pclk), .presetn(presetn), .fire(fire),
      .slow(slow), .slot_valid(slot_valid), .slot_strobe(slot_strobe),
      .n_seen(n_seen));

   // Clock and hang guard; the run needs well under a thousand cycles
   always #12.5 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         close_out();
      end
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Oversize fields saturate before the sum is formed
   function automatic logic [14:0] exp_scr(input int i, k, m);
      int n;
      n = 16 * (i > 511 ? 511 : i) + (k > 15 ? 15 : k);
      n = n + (m == 1 ? 16384 : (m == 2 ? 8192 : 0));
      return n[14:0];
   endfunction

   task automatic close_out();
      $display("Checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, g);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One APB transfer; waits for pready rather than assuming it
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Ends on pready; without it only the bench-wide cycle limit ends this wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic scr(input int i, k, m);
      logic [14:0] x;
      x = exp_scr(i, k, m);
      apb(1'b1, wsf_pkg::OFS_SCR_CFG, 32'(i | (k << 16) | (m << 24)));
      repeat (2) @(posedge pclk);
      chk("scr_code_num", 32'(x), 32'(scr_code_num));
      apb(1'b0, wsf_pkg::OFS_SCR_NUM, 32'h0);
      chk("scr_num_reg", 32'(x), rd);
   endtask

   // Ask the far side for one slot and compare every field but slot_chan, sch_len and, where tp is 0, tpc_up and tpc_field
   task automatic slot(input logic s, input int len, d1, d2, tf, tp, pl,
                       fb, input logic dtx);
      int t;
      logic b;
      b = pat[14 - xs_slot];
      @(posedge pclk);
      fire <= 1'b1;
      slow <= s;
      @(posedge pclk);
      fire <= 1'b0;
      t = 0;
      do begin
         @(posedge pclk);
         t++;
      end while (!(slot_valid === 1'b1) && t < 20);
      chk("slot_valid", 1, 32'(slot_valid));
      chk("slot_index", xs_slot, 32'(slot_index));
      chk("slot_len", len, 32'(slot_len));
      chk("data1", d1, 32'(data1_len));
      chk("data2", d2, 32'(data2_len));
      chk("tfci", tf, 32'(tfci_len));
      chk("tpc", tp, 32'(tpc_len));
      chk("pilot", pl, 32'(pilot_len));
      chk("fbi", fb, 32'(fbi_len));
      chk("tfci_dtx", 32'(dtx), 32'(tfci_dtx));
      if (tp != 0) begin
         chk("tpc_up", 32'(b), 32'(tpc_up));
         chk("tpc_field", b ? 32'hff >> (8 - tp) : 0, 32'(tpc_field));
      end
      xs_slot = (xs_slot + 1) % 15;
   endtask

   // Main sequence
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("scr_rst", 0, 32'(scr_code_num));
      chk("irq_rst", 0, 32'(irq));
      apb(1'b0, 8'h40, 32'h0);
      chk("bad_err", 1, 32'(er));
      chk("bad_rd", 0, rd);
      for (j = 0; j < 7; j++) scr(ci[j], ck[j], cm[j]);
      for (j = 0; j < 24; j++) scr(xs() % 512, xs() % 16, xs() % 3);
      // Saturation raises a status bit; the mask gates the line
      scr(1023, 31, 0);
      chk("irq_masked", 0, 32'(irq));
      apb(1'b1, wsf_pkg::OFS_IRQ_MASK, 32'h1);
      repeat (2) @(posedge pclk);
      chk("irq_cfg", 1, 32'(irq));
      scr(5, 3, 1);
      apb(1'b1, wsf_pkg::OFS_IRQ_STAT, 32'h1);
      repeat (2) @(posedge pclk);
      chk("irq_clr", 0, 32'(irq));
      rd = xs();
      pat = rd[14:0];
      apb(1'b1, wsf_pkg::OFS_TPC_PAT, 32'(pat));
      // Downlink formats, indicator use drawn at random
      for (j = 0; j < 9; j++) begin
         sf = j < 4 ? 0 : j - 3;
         fm = j < 4 ? j : 0;
         u = xs() % 2;
         apb(1'b1, wsf_pkg::OFS_SLOT_CFG,
             32'(1 | sf << 4 | fm << 8 | u << 12));
         u = (sf == 0 ? (fm % 2) * 2 : 8) * 2 + u;
         slot(j % 2, dl_len[sf], dl_d1[sf], sf == 0 ? 28 - 2 * fm : dl_d2[sf],
              u / 2, dl_tp[sf], sf == 0 ? (fm > 1 ? 8 : 4) : dl_pl[sf], 0,
              u > 1 && u % 2 == 0);
      end
      for (j = 0; j < 7; j++) begin
         apb(1'b1, wsf_pkg::OFS_SLOT_CFG, 32'(2 | j << 4));
         slot(j % 2, 10 << j, 0, 10 << j, 0, 0, 0, 0, 1'b0);
      end
      for (j = 0; j < 6; j++) begin
         apb(1'b1, wsf_pkg::OFS_SLOT_CFG, 32'(3 | j << 8));
         slot(1'b0, 10, 0, 0, uc_tf[j], uc_tp[j], uc_pl[j], uc_fb[j], 1'b0);
      end
      apb(1'b1, wsf_pkg::OFS_SLOT_CFG, 32'h0);
      slot(1'b0, 10, 9, 0, 0, 0, 0, 0, 1'b0);
      chk("sch", 1, 32'(sch_len));
      chk("pcc_chan", 0, 32'(slot_chan));
      apb(1'b1, wsf_pkg::OFS_SLOT_CFG, 32'h603);
      slot(1'b0, 0, 0, 0, 0, 0, 0, 0, 1'b0);
      apb(1'b0, wsf_pkg::OFS_IRQ_STAT, 32'h0);
      chk("fmt_err", 1, 32'(rd[2]));
      // Whole frame back to back, far side strobing every cycle
      apb(1'b1, wsf_pkg::OFS_SLOT_CFG, 32'h1);
      apb(1'b1, wsf_pkg::OFS_IRQ_STAT, 32'h7);
      apb(1'b1, wsf_pkg::OFS_IRQ_MASK, 32'h2);
      j = 32'(n_seen);
      @(posedge pclk);
      fire <= 1'b1;
      repeat (15) @(posedge pclk);
      fire <= 1'b0;
      repeat (5) @(posedge pclk);
      chk("n_slots", 15, 32'(n_seen) - j);
      chk("last_idx", (xs_slot + 14) % 15, 32'(slot_index));
      chk("frame_chan", 1, 32'(slot_chan));
      chk("irq_wrap", 1, 32'(irq));
      close_out();
   end
endmodule
`default_nettype wire

//--- dv/wsf_dp_model.sv
// Purpose: Far-side spreading datapath that asks the block for slots.
// Assumes: Same clock as the block; slot_strobe is high one cycle per slot asked for.
// Notes:   Slow mode waits three cycles, and ignores fire meanwhile.
`timescale 1ns/1ps
`default_nettype none
module wsf_dp_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic fire,
   input wire logic slow,
   input wire logic slot_valid,
   output logic slot_strobe,
   output logic [15:0] n_seen
);
   logic [1:0] wait_q;
   // Strobe engine; a held fire gives a strobe every cycle in fast mode, every fourth cycle in slow
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_q <= 2'h0;
         slot_strobe <= 1'b0;
         n_seen <= 16'h0000;
      end else begin
         slot_strobe <= 1'b0;
         if (wait_q != 2'h0) begin
            wait_q <= wait_q - 2'h1;
            slot_strobe <= (wait_q == 2'h1);
         end else if (fire) begin
            if (slow) begin
               wait_q <= 2'h3;
            end else begin
               slot_strobe <= 1'b1;
            end
         end
         if (slot_valid) begin
            n_seen <= n_seen + 16'h0001;
         end
      end
   end
endmodule
`default_nettype wire

//--- hdl/wsf_clamp.sv
// Purpose: Saturate a configuration field to its largest legal value.
// Assumes: Purely combinational; the caller registers the result.
// Notes:   Used for the code field and the offset field.
`timescale 1ns/1ps
`default_nettype none
module wsf_clamp #(
   parameter int WI = 10,
   parameter logic [WI-1:0] MAXV = '1
) (
   input wire logic [WI-1:0] raw,
   output logic [WI-1:0] val,
   output logic over
);

   // Out-of-range values saturate and raise a flag
   always_comb begin
      over = (raw > MAXV);
      val = over ? MAXV : raw;
   end

endmodule
`default_nettype wire

//--- hdl/wsf_pkg.sv
// Purpose: Shared constants and types for the scramble index and slot
//          format block.
// Assumes: APB with 32-bit data, one clock, byte addresses word aligned.
// Notes:   Table lengths are coded in the main module's layout function.
package wsf_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_SCR_CFG = 8'h00;
   localparam logic [7:0] OFS_SCR_NUM = 8'h04;
   localparam logic [7:0] OFS_SLOT_CFG = 8'h08;
   localparam logic [7:0] OFS_TPC_PAT = 8'h0c;
   localparam logic [7:0] OFS_LAYOUT0 = 8'h10;
   localparam logic [7:0] OFS_LAYOUT1 = 8'h14;
   localparam logic [7:0] OFS_SLOT_STAT = 8'h18;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h1c;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h20;

   // Field positions
   localparam int POS_CODE = 0;
   localparam int POS_OFFS = 16;
   localparam int POS_STYPE = 24;
   localparam int POS_CHAN = 0;
   localparam int POS_SF = 4;
   localparam int POS_FMT = 8;
   localparam int POS_TFCI_USED = 12;
   localparam int POS_D2 = 16;
   localparam int POS_TFCI = 8;
   localparam int POS_TPC = 12;
   localparam int POS_PILOT = 16;
   localparam int POS_FBI = 24;
   localparam int POS_SCH = 28;

   // Reset values
   localparam logic [14:0] RST_TPC_PAT = 15'h0000;
   localparam logic [2:0] RST_IRQ_MASK = 3'h0;

   // Interrupt status bits
   localparam int IRQ_CFG_ERR = 0;
   localparam int IRQ_FRAME = 1;
   localparam int IRQ_FMT_ERR = 2;

   // Scrambling arithmetic
   localparam logic [9:0] CODE_MAX = 10'h1ff;
   localparam logic [4:0] OFFS_MAX = 5'h0f;
   localparam logic [14:0] ADD_RIGHT = 15'h4000;
   localparam logic [14:0] ADD_LEFT = 15'h2000;
   localparam logic [14:0] SCR_NUM_MAX = 15'h5fff;
   localparam logic [14:0] STD_PRIM_MAX = 15'h1ff0;
   localparam logic [14:0] STD_MAX = 15'h1fff;

   // Frame timing
   localparam logic [3:0] SLOT_LAST = 4'he;
   localparam logic [10:0] UL_DATA_BASE = 11'h00a;

   typedef enum logic [1:0] {
      WSF_STD,
      WSF_RIGHT,
      WSF_LEFT,
      WSF_BADTYPE
   } wsf_stype_type;

   typedef enum logic [1:0] {
      WSF_PCCPCH,
      WSF_DL_DPCH,
      WSF_UL_DPDCH,
      WSF_UL_DPCCH
   } wsf_chan_type;

   typedef struct packed {
      logic [10:0] slot_len;
      logic [7:0] data1;
      logic [10:0] data2;
      logic [3:0] tfci;
      logic [3:0] tpc;
      logic [4:0] pilot;
      logic [1:0] fbi;
      logic [1:0] sch;
      logic err;
   } wsf_layout_type;

   typedef struct packed {
      logic [9:0] code;
      logic [4:0] offs;
      logic [1:0] stype;
      logic [14:0] scr_num;
      logic [1:0] chan;
      logic [2:0] sf;
      logic [2:0] fmt;
      logic tfci_used;
      logic [14:0] tpc_pat;
      logic [3:0] slot;
      logic [3:0] out_slot;
      logic [1:0] out_chan;
      wsf_layout_type lay;
      logic vld;
      logic tfci_dtx;
      logic [7:0] tpc_field;
      logic tpc_up;
      logic [2:0] irq_stat;
      logic [2:0] irq_mask;
      logic [31:0] prdata;
   } wsf_state_type;

endpackage

//--- hdl/wsf_scramble_slot.sv
// Purpose: Scrambling code number and per-slot field layout over APB.
// Assumes: 40 MHz pclk; slot_strobe comes from logic on the same clock.
// Notes:   APB answers with zero wait states; reads are prepared in the
//          setup cycle so prdata is a flop in the access cycle.
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module wsf_scramble_slot (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic slot_strobe,
   output logic slot_valid,
   output logic [3:0] slot_index,
   output logic [1:0] slot_chan,
   output logic [10:0] slot_len,
   output logic [7:0] data1_len,
   output logic [10:0] data2_len,
   output logic [3:0] tfci_len,
   output logic [3:0] tpc_len,
   output logic [4:0] pilot_len,
   output logic [1:0] fbi_len,
   output logic [1:0] sch_len,
   output logic tfci_dtx,
   output logic [7:0] tpc_field,
   output logic tpc_up,
   output logic [14:0] scr_code_num,
   output logic irq
);

   wsf_pkg::wsf_state_type s_q;
   wsf_pkg::wsf_state_type s_d;
   logic [9:0] code_c;
   logic [4:0] offs_c;
   logic code_over;
   logic offs_over;
   logic [14:0] type_add;
   logic [14:0] scr_calc;
   logic addr_ok;
   wsf_pkg::wsf_layout_type lay_c;

   // Saturating field limits, one instance per field
   wsf_clamp #(.WI(10), .MAXV(wsf_pkg::CODE_MAX)) u_code_clamp (
      .raw(s_q.code),
      .val(code_c),
      .over(code_over)
   );
   wsf_clamp #(.WI(5), .MAXV(wsf_pkg::OFFS_MAX)) u_offs_clamp (
      .raw(s_q.offs),
      .val(offs_c),
      .over(offs_over)
   );

   // Builds one layout record
   function automatic wsf_pkg::wsf_layout_type mk(
      input logic [10:0] sl, input logic [7:0] d1, input logic [10:0] d2,
      input logic [3:0] tf, input logic [3:0] tp, input logic [4:0] pl,
      input logic [1:0] fb, input logic [1:0] sc, input logic er);
      wsf_pkg::wsf_layout_type r;
      r.slot_len = sl;
      r.data1 = d1;
      r.data2 = d2;
      r.tfci = tf;
      r.tpc = tp;
      r.pilot = pl;
      r.fbi = fb;
      r.sch = sc;
      r.err = er;
      return r;
   endfunction

   // Slot field lengths for the selected channel, spread and format
   function automatic wsf_pkg::wsf_layout_type layout(
      input logic [1:0] ch, input logic [2:0] sf, input logic [2:0] fm);
      wsf_pkg::wsf_layout_type r;
      r = mk(11'h000, 8'h00, 11'h000, 4'h0, 4'h0, 5'h00, 2'h0, 2'h0, 1'b1);
      case (ch)
         wsf_pkg::WSF_PCCPCH: begin
            r = mk(11'h00a, 8'h09, 11'h000, 4'h0, 4'h0, 5'h00, 2'h0, 2'h1,
               1'b0);
         end
         wsf_pkg::WSF_DL_DPCH: begin
            case (sf)
               3'h0: begin
                  // Indicator and pilot both vary with format at SF128
                  if (fm <= 3'h3) begin
                     r = mk(11'h028, 8'h06, 11'h01c - 11'({fm[1:0], 1'b0}),
                        {2'h0, fm[0], 1'b0}, 4'h2,
                        fm[1] ? 5'h08 : 5'h04, 2'h0, 2'h0, 1'b0);
                  end
               end
               3'h1: r = mk(11'h050, 8'h0c, 11'h030, 4'h8, 4'h4, 5'h08,
                  2'h0, 2'h0, 1'b0);
               3'h2: r = mk(11'h0a0, 8'h1c, 11'h070, 4'h8, 4'h4, 5'h08,
                  2'h0, 2'h0, 1'b0);
               3'h3: r = mk(11'h140, 8'h38, 11'h0e8, 4'h8, 4'h8, 5'h10,
                  2'h0, 2'h0, 1'b0);
               3'h4: r = mk(11'h280, 8'h78, 11'h1e8, 4'h8, 4'h8, 5'h10,
                  2'h0, 2'h0, 1'b0);
               3'h5: r = mk(11'h500, 8'hf8, 11'h3e8, 4'h8, 4'h8, 5'h10,
                  2'h0, 2'h0, 1'b0);
               default: r.err = 1'b1;
            endcase
         end
         wsf_pkg::WSF_UL_DPDCH: begin
            // Data only; doubles each time the spread factor halves
            if (sf <= 3'h6) begin
               r = mk(wsf_pkg::UL_DATA_BASE << sf, 8'h00,
                  wsf_pkg::UL_DATA_BASE << sf, 4'h0, 4'h0, 5'h00, 2'h0,
                  2'h0, 1'b0);
            end
         end
         default: begin
            case (fm)
               3'h0: r = mk(11'h00a, 8'h00, 11'h000, 4'h2, 4'h2, 5'h06,
                  2'h0, 2'h0, 1'b0);
               3'h1: r = mk(11'h00a, 8'h00, 11'h000, 4'h0, 4'h2, 5'h08,
                  2'h0, 2'h0, 1'b0);
               3'h2: r = mk(11'h00a, 8'h00, 11'h000, 4'h2, 4'h2, 5'h05,
                  2'h1, 2'h0, 1'b0);
               3'h3: r = mk(11'h00a, 8'h00, 11'h000, 4'h0, 4'h2, 5'h07,
                  2'h1, 2'h0, 1'b0);
               3'h4: r = mk(11'h00a, 8'h00, 11'h000, 4'h0, 4'h2, 5'h06,
                  2'h2, 2'h0, 1'b0);
               3'h5: r = mk(11'h00a, 8'h00, 11'h000, 4'h2, 4'h1, 5'h05,
                  2'h2, 2'h0, 1'b0);
               default: r.err = 1'b1;
            endcase
         end
      endcase
      return r;
   endfunction

   // Scrambling arithmetic; widest case 8176+15+16384 fits 15 bits
   always_comb begin
      case (s_q.stype)
         wsf_pkg::WSF_RIGHT: type_add = wsf_pkg::ADD_RIGHT;
         wsf_pkg::WSF_LEFT: type_add = wsf_pkg::ADD_LEFT;
         default: type_add = 15'h0000;
      endcase
      scr_calc = {1'b0, code_c, 4'h0} + {10'h000, offs_c} + type_add;
      lay_c = layout(s_q.chan, s_q.sf, s_q.fmt);
      case (paddr)
         wsf_pkg::OFS_SCR_CFG, wsf_pkg::OFS_SCR_NUM, wsf_pkg::OFS_SLOT_CFG,
         wsf_pkg::OFS_TPC_PAT, wsf_pkg::OFS_LAYOUT0, wsf_pkg::OFS_LAYOUT1,
         wsf_pkg::OFS_SLOT_STAT, wsf_pkg::OFS_IRQ_STAT,
         wsf_pkg::OFS_IRQ_MASK: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end

   // Next state: bus access, number, slot emission, interrupts
   always_comb begin
      logic wr;
      logic [2:0] set;
      logic [2:0] clr;
      logic bit_now;
      wr = psel & penable & pwrite & addr_ok;
      set = 3'h0;
      clr = 3'h0;
      bit_now = 1'b0;
      s_d = s_q;
      s_d.vld = 1'b0;
      if (wr) begin
         case (paddr)
            wsf_pkg::OFS_SCR_CFG: begin
               s_d.code = pwdata[wsf_pkg::POS_CODE +: 10];
               s_d.offs = pwdata[wsf_pkg::POS_OFFS +: 5];
               s_d.stype = pwdata[wsf_pkg::POS_STYPE +: 2];
            end
            wsf_pkg::OFS_SLOT_CFG: begin
               s_d.chan = pwdata[wsf_pkg::POS_CHAN +: 2];
               s_d.sf = pwdata[wsf_pkg::POS_SF +: 3];
               s_d.fmt = pwdata[wsf_pkg::POS_FMT +: 3];
               s_d.tfci_used = pwdata[wsf_pkg::POS_TFCI_USED];
            end
            wsf_pkg::OFS_TPC_PAT: s_d.tpc_pat = pwdata[14:0];
            wsf_pkg::OFS_IRQ_STAT: clr = pwdata[2:0];
            wsf_pkg::OFS_IRQ_MASK: s_d.irq_mask = pwdata[2:0];
            default: s_d.irq_mask = s_q.irq_mask;
         endcase
      end
      // Registered number follows the settings one cycle later
      s_d.scr_num = scr_calc;
      // Bad settings keep flagging while present
      set[wsf_pkg::IRQ_CFG_ERR] = code_over | offs_over |
         (s_q.stype == wsf_pkg::WSF_BADTYPE);
      // Emit the current slot, then step through the 15-slot frame
      if (slot_strobe) begin
         bit_now = s_q.tpc_pat[wsf_pkg::SLOT_LAST - s_q.slot];
         s_d.vld = 1'b1;
         s_d.lay = lay_c;
         s_d.out_slot = s_q.slot;
         s_d.out_chan = s_q.chan;
         s_d.tpc_up = bit_now;
         s_d.tpc_field = {8{bit_now}} &
            8'((9'h001 << lay_c.tpc) - 9'h001);
         s_d.tfci_dtx = (s_q.chan == wsf_pkg::WSF_DL_DPCH) &
            (lay_c.tfci != 4'h0) & ~s_q.tfci_used;
         set[wsf_pkg::IRQ_FMT_ERR] = lay_c.err;
         if (s_q.slot == wsf_pkg::SLOT_LAST) begin
            s_d.slot = 4'h0;
            set[wsf_pkg::IRQ_FRAME] = 1'b1;
         end else begin
            s_d.slot = s_q.slot + 4'h1;
         end
      end
      // Set beats a same-cycle write-one clear
      s_d.irq_stat = (s_q.irq_stat & ~clr) | set;
      // Read data prepared in the setup cycle for a zero-wait access
      if (psel & ~penable & ~pwrite) begin
         case (paddr)
            wsf_pkg::OFS_SCR_CFG: s_d.prdata = {6'h00, s_q.stype,
               3'h0, s_q.offs, 6'h00, s_q.code};
            wsf_pkg::OFS_SCR_NUM: s_d.prdata = {17'h00000, s_q.scr_num};
            wsf_pkg::OFS_SLOT_CFG: s_d.prdata = {19'h00000,
               s_q.tfci_used, 1'b0, s_q.fmt, 1'b0, s_q.sf, 2'h0, s_q.chan};
            wsf_pkg::OFS_TPC_PAT: s_d.prdata = {17'h00000, s_q.tpc_pat};
            wsf_pkg::OFS_LAYOUT0: s_d.prdata = {5'h00, lay_c.data2,
               5'h00, lay_c.slot_len};
            wsf_pkg::OFS_LAYOUT1: s_d.prdata = {2'h0, lay_c.sch,
               2'h0, lay_c.fbi, 3'h0, lay_c.pilot, lay_c.tpc,
               lay_c.tfci, lay_c.data1};
            wsf_pkg::OFS_SLOT_STAT: s_d.prdata = {27'h0000000,
               lay_c.err, s_q.slot};
            wsf_pkg::OFS_IRQ_STAT: s_d.prdata = {29'h00000000,
               s_q.irq_stat};
            wsf_pkg::OFS_IRQ_MASK: s_d.prdata = {29'h00000000,
               s_q.irq_mask};
            default: s_d.prdata = 32'h00000000;
         endcase
      end
   end

   // State register; config comes up at code 0, standard, PCCPCH
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
         s_q.tpc_pat <= wsf_pkg::RST_TPC_PAT;
         s_q.irq_mask <= wsf_pkg::RST_IRQ_MASK;
      end else begin
         s_q <= s_d;
      end
   end

   // Port drive
   assign prdata = s_q.prdata;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~addr_ok;
   assign slot_valid = s_q.vld;
   assign slot_index = s_q.out_slot;
   assign slot_chan = s_q.out_chan;
   assign slot_len = s_q.lay.slot_len;
   assign data1_len = s_q.lay.data1;
   assign data2_len = s_q.lay.data2;
   assign tfci_len = s_q.lay.tfci;
   assign tpc_len = s_q.lay.tpc;
   assign pilot_len = s_q.lay.pilot;
   assign fbi_len = s_q.lay.fbi;
   assign sch_len = s_q.lay.sch;
   assign tfci_dtx = s_q.tfci_dtx;
   assign tpc_field = s_q.tpc_field;
   assign tpc_up = s_q.tpc_up;
   assign scr_code_num = s_q.scr_num;
   assign irq = |(s_q.irq_stat & s_q.irq_mask);

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_formula;
      1 |=> scr_code_num == $past(scr_calc);
   endproperty
   a_formula: assert property (p_formula) else $error("bad number");
   property p_range;
      scr_code_num <= wsf_pkg::SCR_NUM_MAX;
   endproperty
   a_range: assert property (p_range) else $error("out of range");
   property p_clamp;
      (s_q.code > wsf_pkg::CODE_MAX) |-> ##1
         scr_code_num[13:4] == wsf_pkg::CODE_MAX ##0
         s_q.irq_stat[wsf_pkg::IRQ_CFG_ERR];
   endproperty
   a_clamp: assert property (p_clamp) else $error("no clamp");
   property p_second;
      (offs_c != 5'h00) |=> scr_code_num[3:0] != 4'h0;
   endproperty
   a_second: assert property (p_second) else $error("bad offset");
   property p_std_prim;
      (s_q.stype == wsf_pkg::WSF_STD && s_q.offs == 5'h00 && $stable(s_q))
      |=> scr_code_num[3:0] == 4'h0 && scr_code_num <=
         wsf_pkg::STD_PRIM_MAX;
   endproperty
   a_std_prim: assert property (p_std_prim) else $error("not multiple");
   property p_right;
      (s_q.stype == wsf_pkg::WSF_RIGHT) |=> scr_code_num[14];
   endproperty
   a_right: assert property (p_right) else $error("type add");
   property p_dl_sum;
      (slot_valid && slot_chan == wsf_pkg::WSF_DL_DPCH && slot_len != 0)
      |-> 11'(data1_len) + data2_len + 11'(tfci_len) + 11'(tpc_len) +
         11'(pilot_len) == slot_len;
   endproperty
   a_dl_sum: assert property (p_dl_sum) else $error("dl sum");
   property p_sf128;
      (slot_valid && slot_len == 11'h028 &&
         slot_chan == wsf_pkg::WSF_DL_DPCH)
      |-> data1_len == 8'h06 && tpc_len == 4'h2;
   endproperty
   a_sf128: assert property (p_sf128) else $error("sf128 slot");
   property p_pcc;
      (slot_valid && slot_chan == wsf_pkg::WSF_PCCPCH)
      |-> data1_len == 8'h09 && sch_len == 2'h1;
   endproperty
   a_pcc: assert property (p_pcc) else $error("sync slot");
   property p_dtx;
      (slot_strobe && s_q.chan == wsf_pkg::WSF_DL_DPCH && !s_q.tfci_used
         && lay_c.tfci != 4'h0) |=> tfci_dtx;
   endproperty
   a_dtx: assert property (p_dtx) else $error("no dtx");
   property p_ulc;
      (slot_valid && slot_chan == wsf_pkg::WSF_UL_DPCCH && slot_len != 0)
      |-> 5'(tfci_len) + 5'(tpc_len) + pilot_len + 5'(fbi_len) == 5'h0a;
   endproperty
   a_ulc: assert property (p_ulc) else $error("ul ctrl sum");
   property p_tpc;
      slot_strobe |=> tpc_up ==
         $past(s_q.tpc_pat[wsf_pkg::SLOT_LAST - s_q.slot]) &&
         tpc_field[0] == (tpc_up && tpc_len != 4'h0);
   endproperty
   a_tpc: assert property (p_tpc) else $error("tpc bit");
   property p_frame;
      (slot_strobe && s_q.slot == wsf_pkg::SLOT_LAST) |=>
         s_q.slot == 4'h0 && slot_index == wsf_pkg::SLOT_LAST;
   endproperty
   a_frame: assert property (p_frame) else $error("frame wrap");

   c_frame: cover property (slot_valid && slot_index == wsf_pkg::SLOT_LAST);
   c_left: cover property (scr_code_num[13] && !scr_code_num[14]);
   c_dtx: cover property (slot_valid && tfci_dtx);
   c_irq: cover property (irq);

endmodule
`default_nettype wire
